// ===== core/hbgc_defs.svh
// constants for the half-bridge gate controller
`ifndef HBGC_DEFS_SVH
`define HBGC_DEFS_SVH

`define HBGC_CTRL_OFF 8'h00
`define HBGC_PERIOD_OFF 8'h04
`define HBGC_DUTY_OFF 8'h08
`define HBGC_STATUS_OFF 8'h0c
`define HBGC_ISTAT_OFF 8'h10
`define HBGC_ICLR_OFF 8'h14
`define HBGC_IEN_OFF 8'h18

`define HBGC_CTRL_RUN_BIT 0
`define HBGC_CTRL_SKIP_BIT 1
`define HBGC_PERIOD_RST 8'hc7
`define HBGC_DUTY_RST 8'h00

`define HBGC_EV_OT_BIT 0
`define HBGC_EV_LOCK_BIT 1
`define HBGC_EV_DONE_BIT 2

`define HBGC_CLK_NS 25
`define HBGC_ARM_NS 1000
`define HBGC_ARM_CYC ((`HBGC_ARM_NS + `HBGC_CLK_NS - 1) / `HBGC_CLK_NS)

`endif

// ===== core/hbgc_pkg.sv
// types for the half-bridge gate controller
package hbgc_pkg;
   typedef enum logic [1:0]
   {
      ST_OFF = 2'b00,
      ST_ARM = 2'b01,
      ST_SOFT = 2'b11,
      ST_RUN = 2'b10
   } hbgc_state_t;
endpackage

// ===== core/hbgc_sync.sv
// three-stage synchroniser for a pin level
`timescale 1ns/1ps
module hbgc_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_rst,     // synchronous reset
   input wire logic i_async,   // pin level
   output logic o_level        // accepted level
);
   logic s1_reg, s2_reg, s3_reg, lvl_reg;
   logic lvl_next;

   always_comb
   begin
      lvl_next = lvl_reg;
      if (s2_reg == s3_reg)
      begin
         lvl_next = s3_reg;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         lvl_reg <= RST_VAL;
      end
      else
      begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign o_level = lvl_reg;
endmodule

// ===== core/hbgc_ctrl.sv
// half-bridge gate controller: apb registers, sequencing, pwm generation
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "hbgc_defs.svh"
module hbgc_ctrl (
   input wire logic i_clk_sys,             // 40 MHz clock
   input wire logic i_rst,                 // synchronous reset, high
   input wire logic i_psel,                // apb select
   input wire logic i_penable,             // apb enable
   input wire logic i_pwrite,              // apb direction
   input wire logic [7:0] i_paddr,         // apb byte address
   input wire logic [31:0] i_pwdata,       // apb write data
   output logic o_pready,                  // apb ready
   output logic [31:0] o_prdata,           // apb read data
   output logic o_pslverr,                 // apb error, unmapped
   input wire logic i_supply_ok,           // stage supply above lockout
   input wire logic i_overtemp_alarm_n,    // stage alarm pin, low = hot
   output logic o_pwm_out,                 // pwm pin level
   output logic o_pwm_oe,                  // pwm pin drive enable
   output logic o_driver_enable_n_in,      // stage enable pin, high = on
   output logic o_skip_mode_select_n,      // skip pin, low = emulation
   output logic o_irq                      // level interrupt
);
   ////////////////////////////////////////////////////////////////////////////////
   // pin inputs
   logic sup_ok, ot_n;

   hbgc_sync #(.RST_VAL(1'b0)) u_sync_sup (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async(i_supply_ok),
      .o_level(sup_ok)
   );

   hbgc_sync #(.RST_VAL(1'b1)) u_sync_ot (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async(i_overtemp_alarm_n),
      .o_level(ot_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // state
   hbgc_pkg::hbgc_state_t st_reg, st_next;
   logic [7:0] arm_cnt_reg, arm_cnt_next;
   logic [7:0] pcnt_reg, pcnt_next;
   logic [7:0] soft_reg, soft_next;
   logic [1:0] ctrl_reg, ctrl_next;
   logic [7:0] period_reg, period_next;
   logic [7:0] duty_reg, duty_next;
   logic [2:0] ist_reg, ist_next;
   logic [2:0] ien_reg, ien_next;
   logic sup_d_reg, ot_d_reg;
   logic pready_reg, pready_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pslverr_reg, pslverr_next;
   logic pwm_reg, pwm_next, oe_reg, oe_next, en_reg, en_next;
   logic skip_n_reg, skip_n_next, irq_reg, irq_next;
   logic fault, stop, wrap, wr, mapped;
   logic [2:0] ev, clr;
   logic [31:0] rd;

   always_comb
   begin
      fault = ~ot_n | ~sup_ok;
      stop = fault | ~ctrl_reg[`HBGC_CTRL_RUN_BIT];
      wrap = (pcnt_reg >= period_reg);
      wr = i_psel & i_penable & pready_reg & i_pwrite;
      mapped = (i_paddr <= `HBGC_IEN_OFF) && (i_paddr[1:0] == 2'b00);
      st_next = st_reg;
      arm_cnt_next = arm_cnt_reg;
      soft_next = soft_reg;
      pcnt_next = wrap ? 8'h00 : pcnt_reg + 8'h01;
      ev = 3'h0;
      ev[`HBGC_EV_OT_BIT] = ot_d_reg & ~ot_n;
      ev[`HBGC_EV_LOCK_BIT] = sup_d_reg & ~sup_ok;
      case (st_reg)
         hbgc_pkg::ST_OFF:
         begin
            arm_cnt_next = 8'h00;
            soft_next = 8'h00;
            if (!stop)
            begin
               st_next = hbgc_pkg::ST_ARM;
            end
         end
         hbgc_pkg::ST_ARM:
         begin
            if (stop)
            begin
               st_next = hbgc_pkg::ST_OFF;
            end
            else if (arm_cnt_reg == 8'(`HBGC_ARM_CYC - 1))
            begin
               st_next = hbgc_pkg::ST_SOFT;
               soft_next = 8'h00;
               pcnt_next = 8'h00;
            end
            else
            begin
               arm_cnt_next = arm_cnt_reg + 8'h01;
            end
         end
         hbgc_pkg::ST_SOFT:
         begin
            if (stop)
            begin
               st_next = hbgc_pkg::ST_OFF;
            end
            else if (wrap)
            begin
               if (soft_reg >= duty_reg)
               begin
                  st_next = hbgc_pkg::ST_RUN;
                  soft_next = duty_reg;
                  ev[`HBGC_EV_DONE_BIT] = 1'b1;
               end
               else
               begin
                  soft_next = soft_reg + 8'h01;
               end
            end
         end
         hbgc_pkg::ST_RUN:
         begin
            soft_next = duty_reg;
            if (stop)
            begin
               st_next = hbgc_pkg::ST_OFF;
            end
         end
         default:
         begin
            st_next = hbgc_pkg::ST_OFF;
         end
      endcase
      // pin outputs; pwm released to tri-state in off and arm, driven through soft start and run
      en_next = (st_next != hbgc_pkg::ST_OFF);
      oe_next = (st_next == hbgc_pkg::ST_SOFT) || (st_next == hbgc_pkg::ST_RUN);
      pwm_next = oe_next & (pcnt_next < soft_next);
      // emulation during ramp guards against prebiased output
      skip_n_next = ~(ctrl_reg[`HBGC_CTRL_SKIP_BIT] | (st_next == hbgc_pkg::ST_SOFT));
      // registers
      ctrl_next = ctrl_reg;
      period_next = period_reg;
      duty_next = duty_reg;
      ien_next = ien_reg;
      clr = 3'h0;
      if (wr)
      begin
         case (i_paddr)
            `HBGC_CTRL_OFF: ctrl_next = i_pwdata[1:0];
            `HBGC_PERIOD_OFF: period_next = i_pwdata[7:0];
            `HBGC_DUTY_OFF: duty_next = i_pwdata[7:0];
            `HBGC_ICLR_OFF: clr = i_pwdata[2:0];
            `HBGC_IEN_OFF: ien_next = i_pwdata[2:0];
            default: clr = 3'h0;
         endcase
      end
      ist_next = (ist_reg & ~clr) | ev;
      irq_next = |(ist_next & ien_next);
      case (i_paddr)
         `HBGC_CTRL_OFF: rd = {30'h0, ctrl_reg};
         `HBGC_PERIOD_OFF: rd = {24'h0, period_reg};
         `HBGC_DUTY_OFF: rd = {24'h0, duty_reg};
         `HBGC_STATUS_OFF: rd = {16'h0, soft_reg, 4'h0, ~ot_n, ~sup_ok, st_reg};
         `HBGC_ISTAT_OFF: rd = {29'h0, ist_reg};
         `HBGC_IEN_OFF: rd = {29'h0, ien_reg};
         default: rd = 32'h0;
      endcase
      // one wait state: ready rises the cycle after the access phase starts
      pready_next = i_psel & i_penable & ~pready_reg;
      prdata_next = pready_next & ~i_pwrite ? rd : prdata_reg;
      pslverr_next = pready_next & ~mapped;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         st_reg <= hbgc_pkg::ST_OFF;
         arm_cnt_reg <= 8'h00;
         pcnt_reg <= 8'h00;
         soft_reg <= 8'h00;
         ctrl_reg <= 2'h0;
         period_reg <= `HBGC_PERIOD_RST;
         duty_reg <= `HBGC_DUTY_RST;
         ist_reg <= 3'h0;
         ien_reg <= 3'h0;
         sup_d_reg <= 1'b0;
         ot_d_reg <= 1'b1;
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
         pwm_reg <= 1'b0;
         oe_reg <= 1'b0;
         en_reg <= 1'b0;
         skip_n_reg <= 1'b1;
         irq_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         arm_cnt_reg <= arm_cnt_next;
         pcnt_reg <= pcnt_next;
         soft_reg <= soft_next;
         ctrl_reg <= ctrl_next;
         period_reg <= period_next;
         duty_reg <= duty_next;
         ist_reg <= ist_next;
         ien_reg <= ien_next;
         sup_d_reg <= sup_ok;
         ot_d_reg <= ot_n;
         pready_reg <= pready_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
         pwm_reg <= pwm_next;
         oe_reg <= oe_next;
         en_reg <= en_next;
         skip_n_reg <= skip_n_next;
         irq_reg <= irq_next;
      end
   end

   assign o_pready = pready_reg;
   assign o_prdata = prdata_reg;
   assign o_pslverr = pslverr_reg;
   assign o_pwm_out = pwm_reg;
   assign o_pwm_oe = oe_reg;
   assign o_driver_enable_n_in = en_reg;
   assign o_skip_mode_select_n = skip_n_reg;
   assign o_irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   pwm_after_enable_a: assert property (
      $rose(o_pwm_oe) |-> o_driver_enable_n_in && $past(o_driver_enable_n_in, 8))
      else $error("pwm driven before stage enabled long enough");

   // settle wait measured in cycles spent in arm, not taken from the counter
   arm_wait_a: assert property (
      (st_reg == hbgc_pkg::ST_SOFT) && ($past(st_reg) == hbgc_pkg::ST_ARM)
      |-> ($past(st_reg, `HBGC_ARM_CYC) == hbgc_pkg::ST_ARM)
         && ($past(st_reg, `HBGC_ARM_CYC + 1) == hbgc_pkg::ST_OFF))
      else $error("enable settle wait wrong");

   ramp_start_a: assert property (
      (st_reg == hbgc_pkg::ST_ARM) ##1 (st_reg == hbgc_pkg::ST_SOFT)
      |-> soft_reg == 8'h00 ##1 !o_pwm_out)
      else $error("soft start did not begin at zero duty");

   fault_stop_a: assert property (
      fault && (st_reg != hbgc_pkg::ST_OFF)
      |=> (st_reg == hbgc_pkg::ST_OFF) && !o_pwm_oe && !o_driver_enable_n_in && !o_pwm_out)
      else $error("controller kept running after fault");

   run_protect_a: assert property (
      (st_reg == hbgc_pkg::ST_RUN) |-> $past(ot_n) && $past(sup_ok))
      else $error("running with overtemperature or lockout");

   ramp_done_cv: cover property (
      (st_reg == hbgc_pkg::ST_SOFT) ##1 (st_reg == hbgc_pkg::ST_RUN));
   run_fault_cv: cover property ((st_reg == hbgc_pkg::ST_RUN) ##1 (st_reg == hbgc_pkg::ST_OFF));
   irq_clear_cv: cover property (o_irq ##1 wr && (i_paddr == `HBGC_ICLR_OFF) ##1 !o_irq);
endmodule

// ===== sim/hbgc_stage_model.sv
// behavioural model of the power stage seen through its logic pins
`timescale 1ns/1ps
module hbgc_stage_model (
   input wire logic i_pwm_out,            // pwm pin level
   input wire logic i_pwm_oe,             // pwm pin driven
   input wire logic i_driver_enable_n_in, // enable pin
   input wire logic i_skip_mode_select_n, // skip pin
   input wire logic i_supply_on,          // control supply above lockout
   input wire logic i_hot,                // die above alarm limit
   input wire logic i_zero_cross,         // inductor current reversing
   output logic o_supply_ok,              // lockout indication, high = ok
   output logic o_overtemp_alarm_n,       // open-drain alarm, pulled up
   output logic o_high_side_gate_cmd,     // high-side gate
   output logic o_low_side_gate_cmd       // low-side gate
);
   logic lvl = 1'b0;
   logic tri_del;
   logic run;
   // last driven level is kept while the pin floats
   always @*
      if (i_pwm_oe)
         lvl = i_pwm_out;
   assign #(170, 0) tri_del = ~i_pwm_oe;
   assign o_supply_ok = i_supply_on;
   assign o_overtemp_alarm_n = ~i_hot;
   assign run = i_supply_on & i_driver_enable_n_in & ~tri_del;
   assign o_high_side_gate_cmd = run & lvl;
   assign o_low_side_gate_cmd = run & ~lvl & (i_skip_mode_select_n | ~i_zero_cross);
endmodule

// ===== sim/tb_hbgc_ctrl.sv
// self-checking testbench for the gate controller with a stage model
`timescale 1ns/1ps
module tb_hbgc_ctrl;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, sup_ok, alarm_n, pwm_out, pwm_oe, en, skip_n, irq, gh, gl;
   logic sup_on = 1'b1, hot = 1'b0, zc = 1'b0;
   int err_count = 0, comparisons = 0, nh, nl;
   always #12.5 clk = ~clk;
   hbgc_ctrl DUT (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_supply_ok(sup_ok),
      .i_overtemp_alarm_n(alarm_n), .o_pwm_out(pwm_out), .o_pwm_oe(pwm_oe),
      .o_driver_enable_n_in(en), .o_skip_mode_select_n(skip_n), .o_irq(irq));
   hbgc_stage_model stage (.i_pwm_out(pwm_out), .i_pwm_oe(pwm_oe),
      .i_driver_enable_n_in(en), .i_skip_mode_select_n(skip_n), .i_supply_on(sup_on),
      .i_hot(hot), .i_zero_cross(zc), .o_supply_ok(sup_ok), .o_overtemp_alarm_n(alarm_n),
      .o_high_side_gate_cmd(gh), .o_low_side_gate_cmd(gl));
   ////////////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk_reg(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %0t value %h expected %h", $time, g, e);
      end
   endtask
   task chk_pin(input logic g, input logic e);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %0t pin %b expected %b", $time, g, e);
      end
   endtask
   // apb transfer, request held until ready is sampled
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk_reg(rd, e);
   endtask
   task automatic wait_hi(ref logic s);
      while (s !== 1'b1)
         @(posedge clk);
   endtask
   task count8;
      nh = 0;
      nl = 0;
      repeat (8)
      begin
         @(posedge clk);
         nh += int'(gh);
         nl += int'(gl);
      end
   endtask
   task gates_off;
      repeat (10) @(posedge clk);
      chk_pin(gh, 1'b0);
      chk_pin(gl, 1'b0);
      chk_pin(pwm_oe, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'h04, 32'h0000_00c7);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h0c, 32'h0);
      rd_chk(8'h1c, 32'h0);
      chk_pin(er, 1'b1);
      chk_pin(en, 1'b0);
      $display("reset test done");
      apb(1'b1, 8'h04, 32'h3);
      apb(1'b1, 8'h08, 32'h2);
      apb(1'b1, 8'h18, 32'h7);
      apb(1'b1, 8'h00, 32'h3);
      wait_hi(en);
      chk_pin(pwm_oe, 1'b0);
      wait_hi(pwm_oe);
      chk_pin(skip_n, 1'b0);
      chk_pin(pwm_out, 1'b0);
      wait_hi(irq);
      rd_chk(8'h10, 32'h4);
      rd_chk(8'h0c, 32'h202);
      count8;
      chk_reg(32'(nh), 32'h4);
      chk_reg(32'(nl), 32'h4);
      zc <= 1'b1;
      count8;
      chk_reg(32'(nl), 32'h0);
      zc <= 1'b0;
      apb(1'b1, 8'h14, 32'h4);
      @(posedge clk);
      chk_pin(irq, 1'b0);
      $display("soft start test done");
      hot <= 1'b1;
      wait_hi(irq);
      rd_chk(8'h10, 32'h1);
      gates_off;
      chk_pin(en, 1'b0);
      apb(1'b1, 8'h18, 32'h0);
      @(posedge clk);
      chk_pin(irq, 1'b0);
      apb(1'b1, 8'h00, 32'h0);
      hot <= 1'b0;
      apb(1'b1, 8'h14, 32'h1);
      apb(1'b1, 8'h18, 32'h7);
      $display("overtemp test done");
      apb(1'b1, 8'h00, 32'h1);
      wait_hi(en);
      wait_hi(pwm_oe);
      chk_pin(skip_n, 1'b0);
      wait_hi(irq);
      chk_pin(skip_n, 1'b1);
      zc <= 1'b1;
      count8;
      chk_reg(32'(nh), 32'h4);
      chk_reg(32'(nl), 32'h4);
      zc <= 1'b0;
      apb(1'b1, 8'h14, 32'h4);
      @(posedge clk);
      chk_pin(irq, 1'b0);
      sup_on <= 1'b0;
      wait_hi(irq);
      rd_chk(8'h10, 32'h2);
      gates_off;
      $display("lockout test done");
      report_and_stop;
   end
endmodule
